//--- hdl/cmpd_config_mode_pin_decode.v
// cmpd_config_mode_pin_decode.v: decodes the mode pins into a parallel
// configuration interface and steers the shared configuration pins.
// assumes arst_n follows the program pin and that the configuration engine
// supplies data, address and strobe values; this block only routes them.
`timescale 1ns/10ps
`default_nettype none
`include "cmpd_regs.vh"

// How it works
// - mode 100: master parallel, drive clock, d0-15
// - mode 110: slave parallel, select and direction used
// - mode 010: flash master, address and strobes driven
// - shared pins: d16-31 slave x32, a0-15 flash
// - external clock feeds masters only when optioned
// - chain data out only in chain/debug
// - downstream select only in parallel chain
// - revision selects only on reboot or fallback
// - unused pins ignored and high-impedance
module cmpd_config_mode_pin_decode (
    input  wire        clk,                   // core clock, 200 MHz
    input  wire        arst_n,                // program reset, active low
    input  wire [2:0]  mode_pins,             // raw mode pins
    input  wire [1:0]  width_sel,             // port width: 0 x8, 1 x16, 2 x32
    input  wire        config_done,           // configuration completed
    input  wire        ext_clock_option,      // use external master clock
    input  wire        debug_stream_option,   // debug bitstream enabled
    input  wire        serial_chain_en,       // serial daisy chain active
    input  wire        parallel_chain_en,     // parallel daisy chain active
    input  wire        multi_image_reboot,    // reboot event started
    input  wire        fallback_event,        // fallback occurred
    input  wire        fallback_option,       // fallback option enabled
    input  wire        int_config_clock,      // internal clock level
    input  wire        ext_master_clock_in,   // external clock pin
    input  wire        chip_select_n_in,      // chip select pin
    input  wire        port_direction_sel,    // read/write select pin
    input  wire [15:0] low_data_in,           // data pins 0-15
    input  wire [15:0] shared_in,             // shared pins as input
    input  wire [15:0] eng_low_data,          // engine data 0-15 out
    input  wire [15:0] eng_high_data,         // engine data 16-31 out
    input  wire [28:0] eng_flash_addr,        // engine flash address
    input  wire [3:0]  eng_flash_strobes_n,   // cs, oe, we, adv (low active)
    input  wire        eng_chain_data,        // chain data to pass on
    input  wire        eng_downstream_sel_n,  // downstream enable
    input  wire [1:0]  eng_revision,          // revision select value
    output reg  [2:0]  mode_reg,              // latched mode
    output reg         mode_valid_reg,        // mode latched and held
    output reg         config_clock,          // clock pin drive
    output reg         config_clock_oe,       // clock pin enable
    output reg         slave_cs_n_reg,        // synced chip select
    output reg         slave_dir_reg,         // synced direction
    output reg  [31:0] data_in_reg,           // synced data in
    output reg  [15:0] low_data_out,          // data 0-15 drive
    output reg  [15:0] low_data_oe,           // data 0-15 enable
    output reg  [15:0] shared_out,            // shared pins drive
    output reg  [15:0] shared_oe,             // shared pins enable
    output reg  [12:0] high_addr_out,         // address 16-28 drive
    output reg         high_addr_oe,          // address 16-28 enable
    output reg         flash_select_n,        // flash chip select
    output reg         flash_output_en_n,     // flash output enable
    output reg         flash_write_en_n,      // flash write enable
    output reg         flash_addr_valid_n,    // address valid
    output reg         flash_strobe_oe,       // strobe pins enable
    output reg         chain_out_shared_pin,  // chain data / downstream select
    output reg         chain_out_oe,          // shared chain pin enable
    output reg  [1:0]  revision_sel_out,      // revision_sel_1, revision_sel_0
    output reg         revision_sel_oe        // revision pins enable
);
    localparam ST_SAMPLE = 3'h1;
    localparam ST_HOLD   = 3'h2;
    localparam ST_DONE   = 3'h4;

    reg  [2:0]  state_reg;
    reg         rev_hold_reg;
    wire [2:0]  mode_sync;
    wire [1:0]  ctl_sync;
    wire [15:0] low_sync;
    wire [15:0] shared_sync;
    wire        ext_clk_sync;

    cmpd_pin_sync #(.W(38)) u_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .pin_in  ({mode_pins, chip_select_n_in, port_direction_sel,
                   ext_master_clock_in, low_data_in, shared_in}),
        .pin_out ({mode_sync, ctl_sync, ext_clk_sync, low_sync, shared_sync})
    );

    function is_mode;
        input [2:0] m;
        input [2:0] code;
        begin
            is_mode = (m == code);
        end
    endfunction

    wire m_mstr  = mode_valid_reg && is_mode(mode_reg, `CMPD_MODE_MSTR_PAR);
    wire m_slv   = mode_valid_reg && is_mode(mode_reg, `CMPD_MODE_SLV_PAR);
    wire m_flash = mode_valid_reg && is_mode(mode_reg, `CMPD_MODE_FLASH);
    wire w16up   = (width_sel != `CMPD_WIDTH_8);
    wire w32     = (width_sel == `CMPD_WIDTH_32);
    // slave data direction: device drives readback only when direction high
    wire slv_rd  = m_slv && slave_dir_reg && !slave_cs_n_reg;
    wire mst_rd  = m_mstr && slave_dir_reg && !slave_cs_n_reg;

    // mode capture: on the first clock after release, before the sync chain has settled
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg      <= ST_SAMPLE;
            mode_reg       <= `CMPD_SYNC_RST;
            mode_valid_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_SAMPLE: begin
                    mode_reg       <= mode_sync;
                    mode_valid_reg <= 1'b1;
                    state_reg      <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (config_done) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!config_done) begin
                        state_reg <= ST_SAMPLE;                // restart resamples
                    end
                end
                default: begin
                    state_reg <= ST_SAMPLE;
                end
            endcase
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            config_clock       <= 1'b0;
            config_clock_oe    <= 1'b0;
            slave_cs_n_reg     <= 1'b1;
            slave_dir_reg      <= 1'b0;
            data_in_reg        <= 32'h00000000;
            low_data_out       <= 16'h0000;
            low_data_oe        <= 16'h0000;
            shared_out         <= 16'h0000;
            shared_oe          <= 16'h0000;
            high_addr_out      <= 13'h0000;
            high_addr_oe       <= 1'b0;
            flash_select_n     <= 1'b1;
            flash_output_en_n  <= 1'b1;
            flash_write_en_n   <= 1'b1;
            flash_addr_valid_n <= 1'b1;
            flash_strobe_oe    <= 1'b0;
            chain_out_shared_pin <= 1'b0;
            chain_out_oe       <= 1'b0;
            revision_sel_out   <= 2'h0;
            revision_sel_oe    <= 1'b0;
            rev_hold_reg       <= 1'b0;
        end else begin
            // master modes drive the clock; source chosen by option
            config_clock    <= (ext_clock_option ? ext_clk_sync : int_config_clock);
            config_clock_oe <= m_mstr || m_flash;

            // select/direction only live in parallel port modes; flash ignores them
            if (m_mstr || m_slv) begin
                slave_cs_n_reg <= ctl_sync[1];
                slave_dir_reg  <= ctl_sync[0];
            end else begin
                slave_cs_n_reg <= 1'b1;
                slave_dir_reg  <= 1'b0;
            end

            // unused lanes read as zero so stray pin levels never reach the engine
            data_in_reg[7:0]   <= (m_mstr || m_slv || m_flash) ? low_sync[7:0] : 8'h00;
            data_in_reg[15:8]  <= (w16up && (m_mstr || m_slv || m_flash)) ? low_sync[15:8] : 8'h00;
            data_in_reg[31:16] <= (w32 && m_slv) ? shared_sync : 16'h0000;

            low_data_out <= eng_low_data;
            low_data_oe  <= {{8{(w16up && (slv_rd || mst_rd))}}, {8{(slv_rd || mst_rd)}}};

            if (m_flash) begin
                shared_out <= eng_flash_addr[15:0];
                shared_oe  <= 16'hFFFF;
            end else begin
                shared_out <= eng_high_data;
                shared_oe  <= {16{(w32 && slv_rd)}};
            end

            high_addr_out <= eng_flash_addr[28:16];
            high_addr_oe  <= m_flash;
            if (m_flash) begin
                {flash_select_n, flash_output_en_n, flash_write_en_n, flash_addr_valid_n} <=
                    eng_flash_strobes_n;
            end else begin
                {flash_select_n, flash_output_en_n, flash_write_en_n, flash_addr_valid_n} <=
                    `CMPD_FLASH_STROBE_RST;
            end
            flash_strobe_oe <= m_flash;

            // one shared pin: chain data has priority over downstream select
            if (serial_chain_en || debug_stream_option) begin
                chain_out_shared_pin <= eng_chain_data;
                chain_out_oe         <= 1'b1;
            end else if (parallel_chain_en) begin
                chain_out_shared_pin <= eng_downstream_sel_n;
                chain_out_oe         <= 1'b1;
            end else begin
                chain_out_shared_pin <= 1'b0;
                chain_out_oe         <= 1'b0;
            end

            // revision drive holds from the event until the next reset
            if (multi_image_reboot || (fallback_event && fallback_option)) begin
                rev_hold_reg <= 1'b1;
            end
            revision_sel_out <= eng_revision;
            revision_sel_oe  <= rev_hold_reg || multi_image_reboot
                                || (fallback_event && fallback_option);
        end
    end
endmodule
`default_nettype wire

//--- hdl/cmpd_regs.vh
// cmpd_regs.vh: mode codes, pin group widths and reset values for the
// configuration mode pin decoder. definitions only, no logic.
`ifndef CMPD_REGS_VH
`define CMPD_REGS_VH

`define CMPD_MODE_W          3
`define CMPD_MODE_MSTR_PAR   3'h4
`define CMPD_MODE_SLV_PAR    3'h6
`define CMPD_MODE_FLASH      3'h2

`define CMPD_WIDTH_W         2
`define CMPD_WIDTH_8         2'h0
`define CMPD_WIDTH_16        2'h1
`define CMPD_WIDTH_32        2'h2

`define CMPD_LOW_DATA_W      16
`define CMPD_SHARED_W        16
`define CMPD_HIGH_ADDR_W     13
`define CMPD_ADDR_W          29
`define CMPD_REV_W           2

`define CMPD_SYNC_RST        3'h0
`define CMPD_FLASH_STROBE_RST 4'hF

`endif

//--- hdl/cmpd_pin_sync.v
// cmpd_pin_sync.v: three-stage synchroniser with a stable-change filter.
// assumes the input is asynchronous to clk; output follows once the
// second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
module cmpd_pin_sync #(
    parameter W = 1
) (
    input  wire         clk,     // core clock
    input  wire         arst_n,  // async reset, active low
    input  wire [W-1:0] pin_in,  // raw pin level
    output reg  [W-1:0] pin_out  // filtered level
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_reg[i]  <= 1'b0;
                    s2_reg[i]  <= 1'b0;
                    s3_reg[i]  <= 1'b0;
                    pin_out[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= pin_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    // stage one feeds stage two only; agreement filters glitches
                    if (s2_reg[i] == s3_reg[i]) begin
                        pin_out[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- dv/cmpd_config_mode_pin_decode_assertions.sv
// cmpd_config_mode_pin_decode_assertions.sv: pin steering checks for the mode decoder.
// assumes it is bound to the decoder top; outputs trail their cause by one clock.
`timescale 1ns/10ps
`default_nettype none
module cmpd_checker (
    input wire logic        clk,                  // clock
    input wire logic        arst_n,               // reset, active low
    input wire logic [2:0]  mode_reg,             // latched mode
    input wire logic        config_done,          // freezes mode
    input wire logic        serial_chain_en,      // serial chain
    input wire logic        debug_stream_option,  // debug stream
    input wire logic        parallel_chain_en,    // parallel chain
    input wire logic        eng_chain_data,       // chain data
    input wire logic        eng_downstream_sel_n, // downstream enable
    input wire logic [28:0] eng_flash_addr,       // flash address
    input wire logic [3:0]  eng_flash_strobes_n,  // flash strobes
    input wire logic        multi_image_reboot,   // reboot event
    input wire logic        fallback_event,       // fallback event
    input wire logic        fallback_option,      // fallback enabled
    input wire logic        config_clock_oe,      // clock enable
    input wire logic [15:0] shared_out,           // shared drive
    input wire logic [15:0] shared_oe,            // shared enable
    input wire logic [12:0] high_addr_out,        // high address
    input wire logic        high_addr_oe,         // high address enable
    input wire logic        flash_select_n,       // flash select
    input wire logic        flash_output_en_n,    // flash oe
    input wire logic        flash_write_en_n,     // flash we
    input wire logic        flash_addr_valid_n,   // address valid
    input wire logic        flash_strobe_oe,      // strobe enable
    input wire logic        chain_out_shared_pin, // chain pin
    input wire logic        chain_out_oe,         // chain pin enable
    input wire logic        revision_sel_oe       // revision enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_flash_addr;
        $past(mode_reg) == 3'h2 |-> shared_oe == 16'hFFFF && high_addr_oe && {high_addr_out, shared_out} == $past(eng_flash_addr);
    endproperty
    a_flash_addr: assert property (p_flash_addr) else $error("flash address pins wrong");
    property p_flash_strobes;
        $past(mode_reg) == 3'h2 |-> flash_strobe_oe && {flash_select_n, flash_output_en_n, flash_write_en_n, flash_addr_valid_n} == $past(eng_flash_strobes_n);
    endproperty
    a_flash_strobes: assert property (p_flash_strobes) else $error("flash strobes wrong");
    property p_slave_unused;
        $past(mode_reg) == 3'h6 |-> !high_addr_oe && !flash_strobe_oe && !config_clock_oe;
    endproperty
    a_slave_unused: assert property (p_slave_unused) else $error("slave drives unused pins");
    property p_master_pins;
        $past(mode_reg) == 3'h4 |-> config_clock_oe && shared_oe == 16'h0000 && !high_addr_oe && !flash_strobe_oe;
    endproperty
    a_master_pins: assert property (p_master_pins) else $error("master pin set wrong");
    property p_chain_data;
        $past(serial_chain_en) || $past(debug_stream_option) |-> chain_out_oe && chain_out_shared_pin == $past(eng_chain_data);
    endproperty
    a_chain_data: assert property (p_chain_data) else $error("chain data not driven");
    property p_downstream;
        $past(parallel_chain_en) && !$past(serial_chain_en) && !$past(debug_stream_option)
            |-> chain_out_oe && chain_out_shared_pin == $past(eng_downstream_sel_n);
    endproperty
    a_downstream: assert property (p_downstream) else $error("downstream select wrong");
    property p_chain_quiet;
        !$past(serial_chain_en) && !$past(debug_stream_option) && !$past(parallel_chain_en) |-> !chain_out_oe;
    endproperty
    a_chain_quiet: assert property (p_chain_quiet) else $error("chain pin driven while idle");
    property p_rev_cause;
        $rose(revision_sel_oe) |-> $past(multi_image_reboot) || ($past(fallback_event) && $past(fallback_option));
    endproperty
    a_rev_cause: assert property (p_rev_cause) else $error("revision pins driven without event");
    property p_mode_hold;
        config_done && $past(config_done) |-> $stable(mode_reg);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while frozen");
endmodule
bind cmpd_config_mode_pin_decode cmpd_checker u_chk (.*);
`default_nettype wire

//--- dv/cmpd_far_host.sv
// cmpd_far_host.sv: host side of the data pins, resolving each wire.
// assumes the bench gives host value and enable; an undriven line shows the inverse of its last level.
`timescale 1ns/10ps
`default_nettype none
module cmpd_far_host (
    input wire logic        clk,          // clock
    input wire logic [31:0] host_data,    // host drive value
    input wire logic        host_oe,      // host drives
    input wire logic [15:0] low_data_out, // device drive 0-15
    input wire logic [15:0] low_data_oe,  // device enable 0-15
    input wire logic [15:0] shared_out,   // device drive 16-31
    input wire logic [15:0] shared_oe,    // device enable 16-31
    output logic     [15:0] low_data_in,  // wire 0-15
    output logic     [15:0] shared_in     // wire 16-31
);
    logic [31:0] last_q = 32'h00000000;
    always_comb begin
        low_data_in = low_data_oe & low_data_out | ~low_data_oe & (host_oe ? host_data[15:0] : ~last_q[15:0]);
        shared_in = shared_oe & shared_out | ~shared_oe & (host_oe ? host_data[31:16] : ~last_q[31:16]);
    end
    always @(posedge clk) last_q <= {shared_in, low_data_in};
endmodule
`default_nettype wire

//--- dv/testbench.sv
// testbench.sv: mode decode, pin steering, chain and revision pin tests.
// assumes the decoder top and the far host model; inputs change at rising edges.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 0, arst_n = 0, config_done = 0, ext_clock_option = 0, debug_stream_option = 0, serial_chain_en = 0;
    logic parallel_chain_en = 0, multi_image_reboot = 0, fallback_event = 0, fallback_option = 0, int_config_clock = 0;
    logic ext_master_clock_in = 0, chip_select_n_in = 1, port_direction_sel = 0, eng_chain_data = 0;
    logic eng_downstream_sel_n = 0, host_oe = 0, mode_valid_reg, config_clock, config_clock_oe, slave_cs_n_reg;
    logic slave_dir_reg, high_addr_oe, flash_select_n, flash_output_en_n, flash_write_en_n, flash_addr_valid_n;
    logic flash_strobe_oe, chain_out_shared_pin, chain_out_oe, revision_sel_oe;
    logic [2:0] mode_pins = 3'h0, mode_reg;
    logic [1:0] width_sel = 2'h0, eng_revision = 2'h2, revision_sel_out;
    logic [15:0] low_data_in, shared_in, eng_low_data = 16'h9C3A, eng_high_data = 16'h4E71, low_data_out;
    logic [15:0] low_data_oe, shared_out, shared_oe;
    logic [28:0] eng_flash_addr = 29'h15A5C3E1;
    logic [3:0] eng_flash_strobes_n = 4'h5;
    logic [12:0] high_addr_out;
    logic [31:0] data_in_reg, host_data = 32'hA5C35A3C;
    int n_errors = 0, checks_done = 0;
    cmpd_config_mode_pin_decode dut (.*);
    cmpd_far_host u_host (.clk(clk), .host_data(host_data), .host_oe(host_oe), .low_data_out(low_data_out),
        .low_data_oe(low_data_oe), .shared_out(shared_out), .shared_oe(shared_oe), .low_data_in(low_data_in),
        .shared_in(shared_in));
    always #2.5 clk = ~clk;
    always @(posedge clk) int_config_clock <= ~int_config_clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // mode is only resampled after config_done falls, so every change goes through a done pulse
    task automatic set_mode(input logic [2:0] m, input logic [1:0] w);
        mode_pins <= m;
        width_sel <= w;
        config_done <= 1'b1;
        wt(6);
        config_done <= 1'b0;
        wt(8);
        chk(mode_reg, m);
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        test_done;
    end
    initial begin
        wt(12);
        arst_n <= 1'b1;
        wt(2);
        chk({chain_out_oe, revision_sel_oe}, 0);
        set_mode(3'h2, 2'h1);
        chk({high_addr_out, shared_out}, eng_flash_addr);
        chk({shared_oe, high_addr_oe, flash_strobe_oe}, 18'h3FFFF);
        chk({flash_select_n, flash_output_en_n, flash_write_en_n, flash_addr_valid_n}, 4'h5);
        mode_pins <= 3'h6;
        config_done <= 1'b1;
        wt(8);
        chk(mode_reg, 3'h2);
        set_mode(3'h4, 2'h1);
        chk({config_clock_oe, high_addr_oe, flash_strobe_oe, shared_oe}, 19'h40000);
        ext_clock_option <= 1'b1;
        ext_master_clock_in <= 1'b1;
        wt(6);
        chk({config_clock, mode_valid_reg}, 2'h3);
        ext_master_clock_in <= 1'b0;
        wt(6);
        chk(config_clock, 1'b0);
        ext_clock_option <= 1'b0;
        set_mode(3'h6, 2'h2);
        chip_select_n_in <= 1'b0;
        host_oe <= 1'b1;
        wt(8);
        chk(data_in_reg, host_data);
        chk({config_clock_oe, high_addr_oe, flash_strobe_oe}, 0);
        chk(slave_cs_n_reg, 1'b0);
        set_mode(3'h6, 2'h1);
        chk(data_in_reg, {16'h0000, host_data[15:0]});
        host_oe <= 1'b0;
        port_direction_sel <= 1'b1;
        wt(8);
        chk({low_data_oe, low_data_out}, {16'hFFFF, eng_low_data});
        for (int i = 0; i < 4; i++) begin
            {serial_chain_en, debug_stream_option, parallel_chain_en} <= 3'h4 >> i;
            eng_chain_data <= i[0];
            eng_downstream_sel_n <= ~i[0];
            wt(3);
            chk({chain_out_oe, chain_out_shared_pin}, i == 3 ? 2'h0 : {1'b1, i == 2 ? ~i[0] : i[0]});
        end
        fallback_event <= 1'b1;
        wt(3);
        chk(revision_sel_oe, 1'b0);
        fallback_option <= 1'b1;
        wt(3);
        chk({revision_sel_oe, revision_sel_out}, {1'b1, eng_revision});
        fallback_event <= 1'b0;
        arst_n <= 1'b0;
        wt(3);
        arst_n <= 1'b1;
        wt(3);
        chk(revision_sel_oe, 1'b0);
        multi_image_reboot <= 1'b1;
        wt(3);
        chk(revision_sel_oe, 1'b1);
        test_done;
    end
endmodule
`default_nettype wire
